//--- design/ephj_pkg.sv
// Register indices, reset values and filter constants for the edge-interrupt port block
package ephj_pkg;

    localparam int unsigned FILTER_SAMPLES = 4;
    localparam int unsigned WB_ADR_W       = 8;
    localparam int unsigned IDX_W          = 6;

    localparam logic [IDX_W-1:0] IDX_PP_POL   = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_PP_IE    = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_PP_FLAG  = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_PH_DATA  = 6'h20;
    localparam logic [IDX_W-1:0] IDX_PH_PIN   = 6'h21;
    localparam logic [IDX_W-1:0] IDX_PH_DIR   = 6'h22;
    localparam logic [IDX_W-1:0] IDX_PH_RDR   = 6'h23;
    localparam logic [IDX_W-1:0] IDX_PH_PULL  = 6'h24;
    localparam logic [IDX_W-1:0] IDX_PH_POL   = 6'h25;
    localparam logic [IDX_W-1:0] IDX_PH_IE    = 6'h26;
    localparam logic [IDX_W-1:0] IDX_PH_FLAG  = 6'h27;
    localparam logic [IDX_W-1:0] IDX_PJ_DATA  = 6'h28;
    localparam logic [IDX_W-1:0] IDX_PJ_PIN   = 6'h29;
    localparam logic [IDX_W-1:0] IDX_PJ_DIR   = 6'h2a;
    localparam logic [IDX_W-1:0] IDX_PJ_RDR   = 6'h2b;
    localparam logic [IDX_W-1:0] IDX_PJ_PULL  = 6'h2c;
    localparam logic [IDX_W-1:0] IDX_PJ_POL   = 6'h2d;
    localparam logic [IDX_W-1:0] IDX_PJ_IE    = 6'h2e;
    localparam logic [IDX_W-1:0] IDX_PJ_FLAG  = 6'h2f;

    localparam logic [7:0] PJ_IMPL_MASK = 8'hc3;
    localparam logic [7:0] REG_RST      = 8'h00;
    localparam logic [7:0] PH_PULL_RST  = 8'h00;
    localparam logic [7:0] PJ_PULL_RST  = 8'hc3;

    localparam int unsigned PJ_TX_BIT = 7;
    localparam int unsigned PJ_RX_BIT = 6;

endpackage : ephj_pkg

//--- design/ephj_edge_filter.sv
// Per-pin glitch filter and active-edge detector
`timescale 1ns/1ns
module ephj_edge_filter #(
    parameter int unsigned N       = 24,
    parameter int unsigned SAMPLES = ephj_pkg::FILTER_SAMPLES
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [N-1:0] i_level,
    input  wire logic [N-1:0] i_polarity,
    output logic      [N-1:0] o_edge
);
    import ephj_pkg::*;

    typedef struct packed {
        logic [N-1:0][2:0] cnt;
        logic [N-1:0]      armed;
        logic [N-1:0]      edge_seen;
    } ephj_filt_t;

    localparam logic [2:0] LAST = 3'(SAMPLES - 1);

    ephj_filt_t st;
    ephj_filt_t next_st;
    logic       active;

    always_comb begin
        next_st = st;
        active  = 1'b0;
        next_st.edge_seen = '0;
        for (int i = 0; i < N; i++) begin
            // Polarity 1: high is active, 0: low is active
            active = i_level[i] ~^ i_polarity[i];
            if (active) begin
                if (st.armed[i]) begin
                    // Fourth active sample after four passive ones
                    if (st.cnt[i] == LAST) begin
                        next_st.edge_seen[i] = 1'b1;
                        next_st.armed[i]     = 1'b0;
                        next_st.cnt[i]       = 3'h0;
                    end else begin
                        next_st.cnt[i] = st.cnt[i] + 3'h1;
                    end
                end else begin
                    next_st.cnt[i] = 3'h0;
                end
            end else begin
                if (st.armed[i]) begin
                    next_st.cnt[i] = 3'h0;
                end else if (st.cnt[i] == LAST) begin
                    next_st.armed[i] = 1'b1;
                    next_st.cnt[i]   = 3'h0;
                end else begin
                    next_st.cnt[i] = st.cnt[i] + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_edge = st.edge_seen;

endmodule : ephj_edge_filter

//--- design/ephj_gpio_top.sv
// Ports H and J with edge interrupts on ports P, H and J, Wishbone register slave
`timescale 1ns/1ns
module ephj_gpio_top (
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rst,
    input  wire logic                           i_ce,
    input  wire logic                           i_wb_cyc,
    input  wire logic                           i_wb_stb,
    input  wire logic                           i_wb_we,
    input  wire logic [ephj_pkg::WB_ADR_W-1:0]  i_wb_adr,
    input  wire logic [3:0]                     i_wb_sel,
    input  wire logic [31:0]                    i_wb_dat,
    output logic      [31:0]                    o_wb_dat,
    output logic                                o_wb_ack,
    input  wire logic [7:0]                     i_pp_pin,
    output logic      [7:0]                     o_pp_pull_down,
    input  wire logic [7:0]                     i_ph_pin,
    output logic      [7:0]                     o_ph_out,
    output logic      [7:0]                     o_ph_oe,
    output logic      [7:0]                     o_ph_reduced,
    output logic      [7:0]                     o_ph_pull_en,
    output logic      [7:0]                     o_ph_pull_down,
    input  wire logic [7:0]                     i_pj_pin,
    output logic      [7:0]                     o_pj_out,
    output logic      [7:0]                     o_pj_oe,
    output logic      [7:0]                     o_pj_reduced,
    output logic      [7:0]                     o_pj_pull_en,
    output logic      [7:0]                     o_pj_pull_down,
    input  wire logic [7:0]                     i_spi_own,
    input  wire logic [7:0]                     i_spi_out,
    input  wire logic [7:0]                     i_spi_oe,
    input  wire logic                           i_can2_en,
    input  wire logic                           i_can2_tx,
    input  wire logic                           i_i2c_en,
    input  wire logic                           i_i2c_scl_low,
    input  wire logic                           i_i2c_sda_low,
    input  wire logic                           i_can1_en,
    input  wire logic                           i_can1_tx,
    output logic                                o_irq_p,
    output logic                                o_irq_h,
    output logic                                o_irq_j
);
    import ephj_pkg::*;

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        logic [7:0]  pp_s1;
        logic [7:0]  pp_s2;
        logic [7:0]  ph_s1;
        logic [7:0]  ph_s2;
        logic [7:0]  pj_s1;
        logic [7:0]  pj_s2;
        logic [7:0]  pp_pol;
        logic [7:0]  pp_ie;
        logic [7:0]  pp_flag;
        logic [7:0]  ph_data;
        logic [7:0]  ph_dir;
        logic [7:0]  ph_rdr;
        logic [7:0]  ph_pull;
        logic [7:0]  ph_pol;
        logic [7:0]  ph_ie;
        logic [7:0]  ph_flag;
        logic [7:0]  pj_data;
        logic [7:0]  pj_dir;
        logic [7:0]  pj_rdr;
        logic [7:0]  pj_pull;
        logic [7:0]  pj_pol;
        logic [7:0]  pj_ie;
        logic [7:0]  pj_flag;
        logic [7:0]  ph_out;
        logic [7:0]  ph_oe;
        logic [7:0]  ph_red;
        logic [7:0]  ph_pen;
        logic [7:0]  ph_pdn;
        logic [7:0]  pj_out;
        logic [7:0]  pj_oe;
        logic [7:0]  pj_red;
        logic [7:0]  pj_pen;
        logic [7:0]  pj_pdn;
        logic [2:0]  irq;
    } ephj_state_t;

    localparam ephj_state_t ST_RESET = '{pj_pull: PJ_PULL_RST, ph_pull: PH_PULL_RST, default: '0};

    ephj_state_t st;
    ephj_state_t next_st;
    logic [23:0] edges;
    logic        req;
    logic        wr;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [7:0]  ph_oe_c;
    logic [7:0]  ph_out_c;
    logic [7:0]  pj_oe_c;
    logic [7:0]  pj_out_c;
    logic [7:0]  pj_i2c_c;

    // Register index match on a word-aligned address
    function automatic logic hit(input logic [WB_ADR_W-1:0] adr, input logic [IDX_W-1:0] idx);
        hit = (adr[WB_ADR_W-1:2] == idx);
    endfunction : hit

    // Port data read: latch for outputs, pin for inputs
    function automatic logic [7:0] data_rd(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
        data_rd = (dir & lat) | (~dir & pin);
    endfunction : data_rd

    // Write-one-to-clear flag update with set priority
    function automatic logic [7:0] flag_upd(input logic [7:0] flag, input logic [7:0] clr, input logic [7:0] set);
        flag_upd = (flag & ~clr) | set;
    endfunction : flag_upd

    ephj_edge_filter #(
        .N       (24),
        .SAMPLES (FILTER_SAMPLES)
    ) u_filter (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_level    ({st.pj_s2, st.ph_s2, st.pp_s2}),
        .i_polarity ({st.pj_pol, st.ph_pol, st.pp_pol}),
        .o_edge     (edges)
    );

    always_comb begin
        next_st = st;
        req     = i_wb_cyc & i_wb_stb & ~st.ack;
        wr      = req & i_wb_we & i_wb_sel[0];
        wd      = i_wb_dat[7:0];
        rd      = 8'h00;

        // Two-stage pin synchronisers
        next_st.pp_s1 = i_pp_pin;
        next_st.pp_s2 = st.pp_s1;
        next_st.ph_s1 = i_ph_pin;
        next_st.ph_s2 = st.ph_s1;
        next_st.pj_s1 = i_pj_pin;
        next_st.pj_s2 = st.pj_s1;

        // Register writes, pin-input indices have no write path
        if (wr && hit(i_wb_adr, IDX_PP_POL))  next_st.pp_pol  = wd;
        if (wr && hit(i_wb_adr, IDX_PP_IE))   next_st.pp_ie   = wd;
        if (wr && hit(i_wb_adr, IDX_PH_DATA)) next_st.ph_data = wd;
        if (wr && hit(i_wb_adr, IDX_PH_DIR))  next_st.ph_dir  = wd;
        if (wr && hit(i_wb_adr, IDX_PH_RDR))  next_st.ph_rdr  = wd;
        if (wr && hit(i_wb_adr, IDX_PH_PULL)) next_st.ph_pull = wd;
        if (wr && hit(i_wb_adr, IDX_PH_POL))  next_st.ph_pol  = wd;
        if (wr && hit(i_wb_adr, IDX_PH_IE))   next_st.ph_ie   = wd;
        if (wr && hit(i_wb_adr, IDX_PJ_DATA)) next_st.pj_data = wd & PJ_IMPL_MASK;
        if (wr && hit(i_wb_adr, IDX_PJ_DIR))  next_st.pj_dir  = wd & PJ_IMPL_MASK;
        if (wr && hit(i_wb_adr, IDX_PJ_RDR))  next_st.pj_rdr  = wd & PJ_IMPL_MASK;
        if (wr && hit(i_wb_adr, IDX_PJ_PULL)) next_st.pj_pull = wd & PJ_IMPL_MASK;
        if (wr && hit(i_wb_adr, IDX_PJ_POL))  next_st.pj_pol  = wd & PJ_IMPL_MASK;
        if (wr && hit(i_wb_adr, IDX_PJ_IE))   next_st.pj_ie   = wd & PJ_IMPL_MASK;

        // Sticky edge flags with write-one-to-clear
        next_st.pp_flag = flag_upd(st.pp_flag, (wr && hit(i_wb_adr, IDX_PP_FLAG)) ? wd : 8'h00,
                                   edges[7:0]);
        next_st.ph_flag = flag_upd(st.ph_flag, (wr && hit(i_wb_adr, IDX_PH_FLAG)) ? wd : 8'h00,
                                   edges[15:8]);
        next_st.pj_flag = flag_upd(st.pj_flag, (wr && hit(i_wb_adr, IDX_PJ_FLAG)) ? wd : 8'h00,
                                   edges[23:16] & PJ_IMPL_MASK);

        // Read mux, unmapped words read zero
        case (i_wb_adr[WB_ADR_W-1:2])
            IDX_PP_POL:  rd = st.pp_pol;
            IDX_PP_IE:   rd = st.pp_ie;
            IDX_PP_FLAG: rd = st.pp_flag;
            IDX_PH_DATA: rd = data_rd(st.ph_dir, st.ph_data, st.ph_s2);
            IDX_PH_PIN:  rd = st.ph_s2;
            IDX_PH_DIR:  rd = st.ph_dir;
            IDX_PH_RDR:  rd = st.ph_rdr;
            IDX_PH_PULL: rd = st.ph_pull;
            IDX_PH_POL:  rd = st.ph_pol;
            IDX_PH_IE:   rd = st.ph_ie;
            IDX_PH_FLAG: rd = st.ph_flag;
            IDX_PJ_DATA: rd = data_rd(st.pj_dir, st.pj_data, st.pj_s2) & PJ_IMPL_MASK;
            IDX_PJ_PIN:  rd = st.pj_s2 & PJ_IMPL_MASK;
            IDX_PJ_DIR:  rd = st.pj_dir;
            IDX_PJ_RDR:  rd = st.pj_rdr;
            IDX_PJ_PULL: rd = st.pj_pull;
            IDX_PJ_POL:  rd = st.pj_pol;
            IDX_PJ_IE:   rd = st.pj_ie;
            IDX_PJ_FLAG: rd = st.pj_flag;
            default:     rd = 8'h00;
        endcase

        next_st.ack = req;
        if (req) begin
            next_st.rdata = rd;
        end

        // Port H: SPI owns selected pins, else direction bits
        ph_oe_c  = (i_spi_own & i_spi_oe) | (~i_spi_own & st.ph_dir);
        ph_out_c = (i_spi_own & i_spi_out) | (~i_spi_own & st.ph_data);
        next_st.ph_oe  = ph_oe_c;
        next_st.ph_out = ph_out_c;
        next_st.ph_red = st.ph_rdr & ph_oe_c;
        next_st.ph_pen = st.ph_pull & ~ph_oe_c;
        next_st.ph_pdn = st.ph_pol;

        // Port J: general-purpose default on implemented bits
        pj_oe_c   = st.pj_dir & PJ_IMPL_MASK;
        pj_out_c  = st.pj_data & PJ_IMPL_MASK;
        pj_i2c_c  = 8'h00;
        if (i_can2_en) begin
            // Second CAN: transmit out, receive in
            pj_oe_c[PJ_TX_BIT]  = 1'b1;
            pj_out_c[PJ_TX_BIT] = i_can2_tx;
            pj_oe_c[PJ_RX_BIT]  = 1'b0;
            pj_out_c[PJ_RX_BIT] = 1'b0;
        end else if (i_i2c_en) begin
            // I2C: drive low only
            pj_i2c_c[PJ_TX_BIT] = 1'b1;
            pj_i2c_c[PJ_RX_BIT] = 1'b1;
            pj_oe_c[PJ_TX_BIT]  = i_i2c_scl_low;
            pj_out_c[PJ_TX_BIT] = 1'b0;
            pj_oe_c[PJ_RX_BIT]  = i_i2c_sda_low;
            pj_out_c[PJ_RX_BIT] = 1'b0;
        end else if (i_can1_en) begin
            pj_oe_c[PJ_TX_BIT]  = 1'b1;
            pj_out_c[PJ_TX_BIT] = i_can1_tx;
            pj_oe_c[PJ_RX_BIT]  = 1'b0;
            pj_out_c[PJ_RX_BIT] = 1'b0;
        end
        next_st.pj_oe  = pj_oe_c;
        next_st.pj_out = pj_out_c;
        next_st.pj_red = st.pj_rdr & pj_oe_c & ~pj_i2c_c;
        // Pull on inputs and wired-or pins, pull-down only on inputs
        next_st.pj_pen = st.pj_pull & PJ_IMPL_MASK & ((~pj_oe_c & ~pj_i2c_c) | (pj_i2c_c & ~st.pj_pol));
        next_st.pj_pdn = st.pj_pol & ~pj_i2c_c;

        // One request line per port, flag masked by enable
        next_st.irq[0] = |(st.pp_flag & st.pp_ie);
        next_st.irq[1] = |(st.ph_flag & st.ph_ie);
        next_st.irq[2] = |(st.pj_flag & st.pj_ie);
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st <= ST_RESET;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_wb_dat       = {24'h0000_00, st.rdata};
    assign o_wb_ack       = st.ack;
    assign o_pp_pull_down = st.pp_pol;
    assign o_ph_out       = st.ph_out;
    assign o_ph_oe        = st.ph_oe;
    assign o_ph_reduced   = st.ph_red;
    assign o_ph_pull_en   = st.ph_pen;
    assign o_ph_pull_down = st.ph_pdn;
    assign o_pj_out       = st.pj_out;
    assign o_pj_oe        = st.pj_oe;
    assign o_pj_reduced   = st.pj_red;
    assign o_pj_pull_en   = st.pj_pen;
    assign o_pj_pull_down = st.pj_pdn;
    assign o_irq_p        = st.irq[0];
    assign o_irq_h        = st.irq[1];
    assign o_irq_j        = st.irq[2];

endmodule : ephj_gpio_top

//--- sim/ephj_gpio_props.sv
// Checker of bus timing, pad control and interrupt masking
`timescale 1ns/1ns
module ephj_gpio_props
    import ephj_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic [7:0]  o_ph_oe,
    input wire logic [7:0]  o_ph_reduced,
    input wire logic [7:0]  o_ph_pull_en,
    input wire logic [7:0]  o_ph_pull_down,
    input wire logic [7:0]  o_pj_out,
    input wire logic [7:0]  o_pj_oe,
    input wire logic [7:0]  o_pj_reduced,
    input wire logic [7:0]  o_pj_pull_en,
    input wire logic [7:0]  i_spi_own,
    input wire logic [7:0]  i_spi_oe,
    input wire logic        i_can2_en,
    input wire logic        i_can2_tx,
    input wire logic        i_i2c_en,
    input wire logic        i_i2c_scl_low,
    input wire logic        i_i2c_sda_low,
    input wire logic        o_irq_h
);
    logic [7:0] dir_h;
    logic [7:0] pol_h;
    logic [7:0] ie_h;
    logic       wr;
    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0] & ~o_wb_ack & i_ce;
    // Mirror of the port H direction, polarity and interrupt-enable registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dir_h <= 8'h00;
            pol_h <= 8'h00;
            ie_h  <= 8'h00;
        end else if (wr) begin
            if (i_wb_adr[7:2] == IDX_PH_DIR) dir_h <= i_wb_dat[7:0];
            if (i_wb_adr[7:2] == IDX_PH_POL) pol_h <= i_wb_dat[7:0];
            if (i_wb_adr[7:2] == IDX_PH_IE) ie_h <= i_wb_dat[7:0];
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    property p_ack_next;
        i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce |=> o_wb_ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered");
    property p_ack_pulse;
        $rose(o_wb_ack) |=> $fell(o_wb_ack);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_rd_zero;
        o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("upper read data not zero");
    property p_irq_mask;
        $past(ie_h) == 8'h00 && ie_h == 8'h00 |-> !o_irq_h;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked port raised request");
    property p_h_oe;
        o_ph_oe == (($past(dir_h) & ~$past(i_spi_own)) | ($past(i_spi_own) & $past(i_spi_oe)));
    endproperty
    a_h_oe: assert property (p_h_oe) else $error("port H enable wrong");
    property p_h_rdr;
        (o_ph_reduced & ~o_ph_oe) == 8'h00;
    endproperty
    a_h_rdr: assert property (p_h_rdr) else $error("reduced drive on input");
    property p_h_pull;
        (o_ph_pull_en & o_ph_oe) == 8'h00;
    endproperty
    a_h_pull: assert property (p_h_pull) else $error("pull on port H output");
    property p_h_pol;
        (o_ph_pull_en & (o_ph_pull_down ^ $past(pol_h))) == 8'h00;
    endproperty
    a_h_pol: assert property (p_h_pol) else $error("pull direction wrong");
    property p_j_unimpl;
        ((o_pj_out | o_pj_oe | o_pj_pull_en | o_pj_reduced) & ~PJ_IMPL_MASK) == 8'h00;
    endproperty
    a_j_unimpl: assert property (p_j_unimpl) else $error("port J spare bit active");
    property p_can2;
        $past(i_can2_en) |-> o_pj_oe[7] && !o_pj_oe[6] && o_pj_out[7] == $past(i_can2_tx);
    endproperty
    a_can2: assert property (p_can2) else $error("CAN pins not forced");
    property p_i2c;
        $past(i_i2c_en && !i_can2_en) |-> o_pj_oe[7:6] == $past({i_i2c_scl_low, i_i2c_sda_low})
            && (o_pj_out[7:6] & o_pj_oe[7:6]) == 2'b00;
    endproperty
    a_i2c: assert property (p_i2c) else $error("I2C pins not open drain");
    property p_j_pushpull;
        $past(!i_i2c_en || i_can2_en) |-> (o_pj_pull_en & o_pj_oe) == 8'h00;
    endproperty
    a_j_pushpull: assert property (p_j_pushpull) else $error("pull on push-pull output");
endmodule : ephj_gpio_props

bind ephj_gpio_top ephj_gpio_props u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_ph_oe(o_ph_oe),
    .o_ph_reduced(o_ph_reduced), .o_ph_pull_en(o_ph_pull_en), .o_ph_pull_down(o_ph_pull_down),
    .o_pj_out(o_pj_out), .o_pj_oe(o_pj_oe), .o_pj_reduced(o_pj_reduced), .o_pj_pull_en(o_pj_pull_en),
    .i_spi_own(i_spi_own), .i_spi_oe(i_spi_oe), .i_can2_en(i_can2_en), .i_can2_tx(i_can2_tx),
    .i_i2c_en(i_i2c_en), .i_i2c_scl_low(i_i2c_scl_low), .i_i2c_sda_low(i_i2c_sda_low), .o_irq_h(o_irq_h));

//--- sim/ephj_pad_model.sv
// Pad model: drivers, outside sources, pull devices, floating lines
`timescale 1ns/1ns
module ephj_pad_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pull_en,
    input  wire logic [7:0] i_pull_down,
    input  wire logic [7:0] i_ext,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_pin
);
    logic [7:0] flt = 8'h55;
    // Undriven lines change every cycle
    always @(posedge i_clk_sys) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_oe[i]) o_pin[i] = i_out[i];
            else if (i_ext_en[i]) o_pin[i] = i_ext[i];
            else if (i_pull_en[i]) o_pin[i] = ~i_pull_down[i];
            else o_pin[i] = flt[i];
        end
    end
endmodule : ephj_pad_model

//--- sim/ephj_gpio_top_tb.sv
// Self-checking bench for the edge-interrupt port block
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module ephj_gpio_top_tb;
    import ephj_pkg::*;
    logic        clk;
    logic        rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [7:0]  pp = 8'hfb, ext_h = 8'hfb, exten_h = 8'hff, spi_own = 8'h00, spi_oe = 8'h00, spi_out = 8'h00;
    logic        can2_en = 1'b0, can2_tx = 1'b1, i2c_en = 1'b0, scl_low = 1'b0, sda_low = 1'b1;
    logic        can1_en = 1'b0, can1_tx = 1'b0, ack, irq_p, irq_h, irq_j;
    logic [7:0]  pin_h, pin_j, ph_out, ph_oe, ph_rdr, ph_pe, ph_pd, pj_out, pj_oe, pj_rdr, pj_pe, pj_pd, pp_pd;
    int          num_errors = 0, compares = 0;

    ephj_gpio_top DUT (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_pp_pin(pp), .o_pp_pull_down(pp_pd), .i_ph_pin(pin_h), .o_ph_out(ph_out), .o_ph_oe(ph_oe),
        .o_ph_reduced(ph_rdr), .o_ph_pull_en(ph_pe), .o_ph_pull_down(ph_pd), .i_pj_pin(pin_j),
        .o_pj_out(pj_out), .o_pj_oe(pj_oe), .o_pj_reduced(pj_rdr), .o_pj_pull_en(pj_pe),
        .o_pj_pull_down(pj_pd), .i_spi_own(spi_own), .i_spi_out(spi_out), .i_spi_oe(spi_oe),
        .i_can2_en(can2_en), .i_can2_tx(can2_tx), .i_i2c_en(i2c_en), .i_i2c_scl_low(scl_low),
        .i_i2c_sda_low(sda_low), .i_can1_en(can1_en), .i_can1_tx(can1_tx), .o_irq_p(irq_p),
        .o_irq_h(irq_h), .o_irq_j(irq_j));
    ephj_pad_model u_pad_h (.i_clk_sys(clk), .i_out(ph_out), .i_oe(ph_oe), .i_pull_en(ph_pe),
        .i_pull_down(ph_pd), .i_ext(ext_h), .i_ext_en(exten_h), .o_pin(pin_h));
    ephj_pad_model u_pad_j (.i_clk_sys(clk), .i_out(pj_out), .i_oe(pj_oe), .i_pull_en(pj_pe),
        .i_pull_down(pj_pd), .i_ext(8'h00), .i_ext_en(8'h00), .o_pin(pin_j));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, idx, 2'b00, 24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            num_errors++;
            print_verdict;
        end else begin
            q = rdat[7:0];
            {cyc, stb, we} <= 3'b000;
        end
    endtask : wb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(idx, 1'b1, d, q);
    endtask : wr

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] q;
        wb(idx, 1'b0, 8'h00, q);
        `CHK(q, e)
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic pins(input logic [7:0] v, input int n);
        @(posedge clk);
        {ext_h, pp} <= {v, v};
        repeat (n - 1) @(posedge clk);
    endtask : pins

    task automatic t_reset;
        for (logic [6:0] i = 7'h1d; i <= 7'h30; i++) begin
            if (i != 7'h20 && i != 7'h21) rd_chk(i[5:0], (i == 7'h28 || i == 7'h29 || i == 7'h2c) ? 8'hc3 : 8'h00);
        end
        `CHK(ph_pe, 8'h00)
        `CHK({pj_pe, pj_pd}, 16'hc300)
    endtask : t_reset

    task automatic t_portj;
        wr(IDX_PJ_DIR, 8'hff);
        rd_chk(IDX_PJ_DIR, 8'hc3);
        wr(IDX_PJ_RDR, 8'hff);
        settle(2);
        `CHK({pj_oe, pj_rdr}, 16'hc3c3)
        wr(IDX_PJ_PIN, 8'hff);
        rd_chk(IDX_PJ_PIN, 8'h00);
        rd_chk(IDX_PJ_DATA, 8'h00);
        wr(IDX_PJ_IE, 8'hff);
        rd_chk(IDX_PJ_FLAG, 8'hc3);
        `CHK(irq_j, 1'b1)
        wr(IDX_PJ_FLAG, 8'h01);
        rd_chk(IDX_PJ_FLAG, 8'hc2);
        wr(IDX_PJ_FLAG, 8'hff);
        settle(1);
        `CHK(irq_j, 1'b0)
        wr(IDX_PJ_DIR, 8'h00);
        settle(2);
        `CHK(pj_rdr, 8'h00)
        wr(IDX_PJ_RDR, 8'h00);
        wr(IDX_PJ_IE, 8'h00);
    endtask : t_portj

    task automatic t_edges;
        wr(IDX_PH_POL, 8'h04);
        settle(10);
        pins(8'hfa, 3);
        pins(8'hfb, 10);
        pins(8'hf9, 4);
        pins(8'hfb, 10);
        pins(8'hff, 10);
        rd_chk(IDX_PH_FLAG, 8'h06);
        rd_chk(IDX_PP_FLAG, 8'h02);
        `CHK(irq_h, 1'b0)
        `CHK(irq_p, 1'b0)
        wr(IDX_PH_IE, 8'h04);
        settle(1);
        `CHK(irq_h, 1'b1)
        wr(IDX_PH_FLAG, 8'h02);
        rd_chk(IDX_PH_FLAG, 8'h04);
        wr(IDX_PH_FLAG, 8'h04);
        settle(1);
        `CHK(irq_h, 1'b0)
        wr(IDX_PH_IE, 8'h00);
        wr(IDX_PP_IE, 8'h02);
        settle(1);
        `CHK(irq_p, 1'b1)
        wr(IDX_PP_POL, 8'h5a);
        settle(1);
        `CHK(pp_pd, 8'h5a)
    endtask : t_edges

    task automatic t_dir_h;
        wr(IDX_PH_DATA, 8'ha5);
        wr(IDX_PH_DIR, 8'h0f);
        wr(IDX_PH_PULL, 8'hff);
        wr(IDX_PH_POL, 8'hf0);
        wr(IDX_PH_RDR, 8'hff);
        @(posedge clk);
        {spi_own, spi_oe, spi_out, exten_h, ext_h} <= {8'h01, 8'h01, 8'h00, 8'h30, 8'h20};
        settle(3);
        `CHK({ph_oe, ph_out & ph_oe, ph_pe, ph_pd & ph_pe}, 32'h0f04_f0f0)
        `CHK(ph_rdr, 8'h0f)
        rd_chk(IDX_PH_PIN, 8'h24);
        rd_chk(IDX_PH_DATA, 8'h25);
    endtask : t_dir_h

    task automatic t_owner;
        logic [2:0] en [4] = '{3'b111, 3'b011, 3'b001, 3'b000};
        logic [2:0] ex [4] = '{3'b101, 3'b010, 3'b100, 3'b101};
        wr(IDX_PJ_DATA, 8'h80);
        wr(IDX_PJ_DIR, 8'h80);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {can2_en, i2c_en, can1_en} <= en[i];
            settle(2);
            `CHK({pj_oe[7:6], pj_out[7] & pj_oe[7]}, ex[i])
        end
        `CHK({pj_pe, pj_pd}, 16'h4300)
        rd_chk(IDX_PJ_DIR, 8'h80);
    endtask : t_owner

    task automatic print_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_portj;
        t_edges;
        t_dir_h;
        t_owner;
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
endmodule : ephj_gpio_top_tb
